/* hdl/dces_defs.vh */
// Offsets, field positions and reset values of the driver configuration and event select bank.
`ifndef DCES_DEFS_VH
`define DCES_DEFS_VH

`define DCES_ADDR_W 7
`define DCES_ADDR_STEP_SETTINGS 7'h0a
`define DCES_ADDR_SPI_STATUS_SEL 7'h0b
`define DCES_ADDR_CLEAR_PROTECT 7'h0c
`define DCES_ADDR_INTERRUPT_OUT_SEL 7'h0d
`define DCES_ADDR_EVENTS 7'h0e

`define DCES_RST_STEP_SETTINGS 32'h00fb0c80
`define DCES_RST_SPI_STATUS_SEL 32'h82029805
`define DCES_RST_CLEAR_PROTECT 32'h00000000
`define DCES_RST_INTERRUPT_OUT_SEL 32'h00000000
`define DCES_RST_EVENTS 32'h00000000
`define DCES_RST_FSREV 12'h0c8

`define DCES_MSTEP_LSB 0
`define DCES_MSTEP_MSB 3
`define DCES_FSREV_LSB 4
`define DCES_FSREV_MSB 15
`define DCES_DRVSEL_LSB 16
`define DCES_DRVSEL_MSB 23
`define DCES_STEP_USED_MASK 32'h00ffffff

`define DCES_MSTEP_CODE_MAX 4'h8
`define DCES_MSTEP_FULL 9'h100
`define DCES_DRIVER_EVENT_BIT 30
`define DCES_STATUS_BITS 8

`endif

/* hdl/dces_regs.v */
// Driver settings, event flags and event routing to SPI status bits and the interrupt line.
`timescale 1ns/100ps
`include "dces_defs.vh"

module dces_regs
(
   // Clock and reset.
   input wire ref_clk,
   input wire resetn,
   // Register access from the host SPI datagram decoder.
   input wire [`DCES_ADDR_W-1:0] regAddr,
   input wire regWrEn,
   input wire [31:0] regWrData,
   input wire regRdEn,
   output reg [31:0] regRdData_r,
   output reg regRdValid_r,
   // Event sources and driver responses.
   input wire [31:0] eventIn,
   input wire [7:0] driverFlags,
   input wire driverFlagsValid,
   // Results.
   output reg [7:0] driverStatus_r,
   output reg [7:0] spiStatusBits_r,
   output reg interruptOut_r,
   output reg [8:0] microstepsPerFullstep_r,
   output reg [11:0] fullstepsPerRevolution_r
);

////////////////////////////////////////////////////////////////////////////////

reg rstSync1_r;
reg rstSync2_r;
wire rstn;

// The release is synchronised so that no register leaves reset on a different edge.
always @(posedge ref_clk or negedge resetn)
begin
   if (!resetn)
   begin
      rstSync1_r <= 1'b0;
      rstSync2_r <= 1'b0;
   end
   else
   begin
      rstSync1_r <= 1'b1;
      rstSync2_r <= rstSync1_r;
   end
end

assign rstn = rstSync2_r;

////////////////////////////////////////////////////////////////////////////////

reg [31:0] stepSettings_r;
reg [31:0] spiStatusSelect_r;
reg [31:0] clearProtect_r;
reg [31:0] interruptSelect_r;
reg [31:0] events_r;
reg [31:0] events_nxt;
reg [31:0] stepSettings_nxt;
reg [31:0] spiStatusSelect_nxt;
reg [31:0] interruptSelect_nxt;
reg [31:0] clearProtect_nxt;
reg [31:0] rdData_nxt;
reg [7:0] spiStatus_nxt;
reg [8:0] microsteps_nxt;
reg [7:0] driverStatus_nxt;
reg [3:0] fill;
reg driverEvent;
reg eventsRead;
integer i;

always @*
begin
   stepSettings_nxt = stepSettings_r;
   spiStatusSelect_nxt = spiStatusSelect_r;
   clearProtect_nxt = clearProtect_r;
   interruptSelect_nxt = interruptSelect_r;
   if (regWrEn)
   begin
      case (regAddr)
         `DCES_ADDR_STEP_SETTINGS: stepSettings_nxt = regWrData & `DCES_STEP_USED_MASK;
         `DCES_ADDR_SPI_STATUS_SEL: spiStatusSelect_nxt = regWrData;
         `DCES_ADDR_CLEAR_PROTECT: clearProtect_nxt = regWrData;
         `DCES_ADDR_INTERRUPT_OUT_SEL: interruptSelect_nxt = regWrData;
         default: stepSettings_nxt = stepSettings_r;
      endcase
   end
end

// Driver flags are masked before they reach the status set or the event.
always @*
begin
   driverStatus_nxt = driverStatus_r;
   driverEvent = 1'b0;
   if (driverFlagsValid)
   begin
      driverStatus_nxt = driverFlags & stepSettings_r[`DCES_DRVSEL_MSB:`DCES_DRVSEL_LSB];
      driverEvent = |driverStatus_nxt;
   end
end

// A new event in the cycle of the clearing read survives: the set is applied last.
always @*
begin
   eventsRead = regRdEn && (regAddr == `DCES_ADDR_EVENTS);
   events_nxt = events_r;
   if (eventsRead)
   begin
      events_nxt = events_r & clearProtect_r;
   end
   events_nxt = events_nxt | eventIn;
   events_nxt[`DCES_DRIVER_EVENT_BIT] = events_nxt[`DCES_DRIVER_EVENT_BIT] | driverEvent;
end

// Selected events are packed from the LSB upward; extra selections beyond eight are dropped.
always @*
begin
   spiStatus_nxt = 8'h00;
   fill = 4'h0;
   for (i = 0; i < 32; i = i + 1)
   begin
      if (spiStatusSelect_nxt[i] && (fill < `DCES_STATUS_BITS))
      begin
         spiStatus_nxt[fill[2:0]] = events_nxt[i];
         fill = fill + 4'h1;
      end
   end
end

// Illegal codes above full steps decode as full steps rather than a zero count.
always @*
begin
   if (stepSettings_nxt[`DCES_MSTEP_MSB:`DCES_MSTEP_LSB] > `DCES_MSTEP_CODE_MAX)
   begin
      microsteps_nxt = 9'h001;
   end
   else
   begin
      microsteps_nxt = `DCES_MSTEP_FULL >> stepSettings_nxt[`DCES_MSTEP_MSB:`DCES_MSTEP_LSB];
   end
end

always @*
begin
   case (regAddr)
      `DCES_ADDR_STEP_SETTINGS: rdData_nxt = stepSettings_r;
      `DCES_ADDR_SPI_STATUS_SEL: rdData_nxt = spiStatusSelect_r;
      `DCES_ADDR_CLEAR_PROTECT: rdData_nxt = clearProtect_r;
      `DCES_ADDR_INTERRUPT_OUT_SEL: rdData_nxt = interruptSelect_r;
      `DCES_ADDR_EVENTS: rdData_nxt = events_r;
      default: rdData_nxt = 32'h00000000;
   endcase
end

////////////////////////////////////////////////////////////////////////////////

// Configuration registers keep their table values until the host writes them.
always @(posedge ref_clk or negedge rstn)
begin
   if (!rstn)
   begin
      stepSettings_r <= `DCES_RST_STEP_SETTINGS;
      spiStatusSelect_r <= `DCES_RST_SPI_STATUS_SEL;
      clearProtect_r <= `DCES_RST_CLEAR_PROTECT;
      interruptSelect_r <= `DCES_RST_INTERRUPT_OUT_SEL;
   end
   else
   begin
      stepSettings_r <= stepSettings_nxt;
      spiStatusSelect_r <= spiStatusSelect_nxt;
      clearProtect_r <= clearProtect_nxt;
      interruptSelect_r <= interruptSelect_nxt;
   end
end

////////////////////////////////////////////////////////////////////////////////

// Event flags and the captured driver status.
always @(posedge ref_clk or negedge rstn)
begin
   if (!rstn)
   begin
      events_r <= `DCES_RST_EVENTS;
      driverStatus_r <= 8'h00;
   end
   else
   begin
      events_r <= events_nxt;
      driverStatus_r <= driverStatus_nxt;
   end
end

////////////////////////////////////////////////////////////////////////////////

// Status, interrupt and step outputs are computed from next-state values so that they change on the same edge as the
// registers they describe; the host never sees a stale interrupt after writing a mask.
always @(posedge ref_clk or negedge rstn)
begin
   if (!rstn)
   begin
      spiStatusBits_r <= 8'h00;
      interruptOut_r <= 1'b0;
      microstepsPerFullstep_r <= `DCES_MSTEP_FULL;
      fullstepsPerRevolution_r <= `DCES_RST_FSREV;
      regRdData_r <= 32'h00000000;
      regRdValid_r <= 1'b0;
   end
   else
   begin
      spiStatusBits_r <= spiStatus_nxt;
      interruptOut_r <= |(events_nxt & interruptSelect_nxt);
      microstepsPerFullstep_r <= microsteps_nxt;
      fullstepsPerRevolution_r <= stepSettings_nxt[`DCES_FSREV_MSB:`DCES_FSREV_LSB];
      regRdData_r <= regRdEn ? rdData_nxt : 32'h00000000;
      regRdValid_r <= regRdEn;
   end
end

endmodule

/* verification/dces_regs_properties.sv */
// Assertions on the driver settings and event select bank.
`timescale 1ns/100ps
module dces_regs_properties
(
   input ref_clk, resetn, regWrEn, regRdEn, regRdValid_r, driverFlagsValid, interruptOut_r,
   input [6:0] regAddr,
   input [7:0] driverFlags, driverStatus_r, spiStatusBits_r,
   input [8:0] microstepsPerFullstep_r,
   input [11:0] fullstepsPerRevolution_r,
   input [31:0] regWrData, regRdData_r, eventIn
);
   wire wrStep = regWrEn && regAddr == 7'h0a;
   wire wrIntr = regWrEn && regAddr == 7'h0d;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   rd_answer_a: assert property (regRdEn |=> regRdValid_r) else $error("read");
   mstep_code_a: assert property (wrStep && !regWrData[3] |=>
      microstepsPerFullstep_r == 9'h100 >> $past(regWrData[2:0])) else $error("mstep");
   fsrev_field_a: assert property (wrStep |=>
      fullstepsPerRevolution_r == $past(regWrData[15:4])) else $error("fsrev");
   drv_mask_a: assert property (driverFlagsValid |=>
      (driverStatus_r & ~$past(driverFlags)) == 8'h00) else $error("mask");
   // Relies on driver mask bit 16 staying set, as it is at reset and in every test.
   drv_event_a: assert property (driverFlagsValid && driverFlags[0] ##1 regRdEn &&
      regAddr == 7'h0e |=> regRdData_r[30]) else $error("event");
   spi_bit_a: assert property (eventIn[2] |=> spiStatusBits_r[1]) else $error("spi");
   interrupt_out_off_a: assert property (wrIntr && regWrData == 32'h0 |=> !interruptOut_r)
      else $error("interrupt_out");
   interrupt_out_on_a: assert property (wrIntr && regWrData[5] && eventIn[5] |=> interruptOut_r)
      else $error("interrupt_out");
   cover property (driverFlagsValid);
   cover property (regRdValid_r);
   cover property (interruptOut_r);
endmodule
bind dces_regs dces_regs_properties i_props
(
   .ref_clk(ref_clk),
   .resetn(resetn),
   .regWrEn(regWrEn),
   .regRdEn(regRdEn),
   .regRdValid_r(regRdValid_r),
   .driverFlagsValid(driverFlagsValid),
   .interruptOut_r(interruptOut_r),
   .regAddr(regAddr),
   .driverFlags(driverFlags),
   .driverStatus_r(driverStatus_r),
   .spiStatusBits_r(spiStatusBits_r),
   .microstepsPerFullstep_r(microstepsPerFullstep_r),
   .fullstepsPerRevolution_r(fullstepsPerRevolution_r),
   .regWrData(regWrData),
   .regRdData_r(regRdData_r),
   .eventIn(eventIn)
);

/* verification/dces_drv_model.sv */
// Stepper driver model answering with status flags.
`timescale 1ns/100ps
module dces_drv_model
(
   input ref_clk, reqGo,
   input [7:0] reqFlags,
   output reg driverFlagsValid = 1'h0,
   output reg [7:0] driverFlags = 8'h00
);
   // Between answers the flag lines carry junk, so the block must honour valid.
   always @(posedge ref_clk)
      {driverFlagsValid, driverFlags} <= #5 {reqGo, reqGo ? reqFlags : ~driverFlags};
endmodule

/* verification/driver_config_event_select_tb.sv */
// Self-checking bench for the driver settings and event select bank.
`timescale 1ns/100ps
module driver_config_event_select_tb;
   localparam W = 1'h1, R = 1'h0;
   reg ref_clk = 1'h0, resetn = 1'h0, regWrEn = 1'h0, regRdEn = 1'h0, reqGo = 1'h0;
   reg [6:0] regAddr = 7'h00;
   reg [7:0] reqFlags = 8'h00;
   reg [31:0] regWrData = 32'h0, eventIn = 32'h0;
   wire regRdValid_r, driverFlagsValid, interruptOut_r;
   wire [7:0] driverFlags, driverStatus_r, spiStatusBits_r;
   wire [8:0] microstepsPerFullstep_r;
   wire [11:0] fullstepsPerRevolution_r;
   wire [31:0] regRdData_r;
   integer error_cnt = 0, checked = 0, c;
   dces_regs i_dces_regs
   (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .regAddr(regAddr),
      .regWrEn(regWrEn),
      .regWrData(regWrData),
      .regRdEn(regRdEn),
      .regRdData_r(regRdData_r),
      .regRdValid_r(regRdValid_r),
      .eventIn(eventIn),
      .driverFlags(driverFlags),
      .driverFlagsValid(driverFlagsValid),
      .driverStatus_r(driverStatus_r),
      .spiStatusBits_r(spiStatusBits_r),
      .interruptOut_r(interruptOut_r),
      .microstepsPerFullstep_r(microstepsPerFullstep_r),
      .fullstepsPerRevolution_r(fullstepsPerRevolution_r)
   );
   dces_drv_model i_dces_drv_model
   (
      .ref_clk(ref_clk),
      .reqGo(reqGo),
      .reqFlags(reqFlags),
      .driverFlagsValid(driverFlagsValid),
      .driverFlags(driverFlags)
   );
   initial forever #25 ref_clk = ~ref_clk;
   task chk(input [31:0] s, e);
   begin
      checked = checked + 1;
      if (s !== e)
      begin
         error_cnt = error_cnt + 1;
         $display("BAD %0t got %h", $time, s);
      end
   end
   endtask
   task acc(input w, input [6:0] a, input [31:0] d);
   begin
      regAddr = a;
      regWrData = d;
      regWrEn = w;
      regRdEn = !w;
      @(posedge ref_clk) #5;
      regWrEn = 1'h0;
      regRdEn = 1'h0;
      if (!w)
      begin
         chk(regRdData_r, d);
         chk(regRdValid_r, 1'h1);
      end
      // An idle cycle keeps a strobe from being lowered and raised in one time step.
      @(posedge ref_clk) #5;
   end
   endtask
   task drv(input [7:0] f);
   begin
      reqFlags = f;
      reqGo = 1'h1;
      @(posedge ref_clk) #5;
      reqGo = 1'h0;
      @(posedge ref_clk) #5;
   end
   endtask
   task stop_test;
   begin
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   initial
   begin
      repeat (3) @(posedge ref_clk);
      #5 resetn = 1'h1;
      repeat (3) @(posedge ref_clk) #5;
      chk(fullstepsPerRevolution_r, 12'h0c8);
      chk(microstepsPerFullstep_r, 9'h100);
      acc(R, 7'h0b, 32'h82029805);
      $display("t1 end");
      for (c = 0; c < 10; c = c + 1)
      begin
         acc(W, 7'h0a, {16'hfffb, 12'h123, c[3:0]});
         chk(microstepsPerFullstep_r, c > 8 ? 9'h001 : 9'h100 >> c);
      end
      chk(fullstepsPerRevolution_r, 12'h123);
      acc(R, 7'h0a, 32'h00fb1239);
      acc(W, 7'h0a, 32'h00fb0c80);
      chk(microstepsPerFullstep_r, 9'h100);
      acc(W, 7'h0d, 32'h40000000);
      drv(8'h04);
      chk(driverStatus_r, 8'h00);
      chk(interruptOut_r, 1'h0);
      drv(8'h05);
      chk(driverStatus_r, 8'h01);
      chk(interruptOut_r, 1'h1);
      acc(R, 7'h0e, 32'h40000000);
      acc(W, 7'h0d, 32'h0);
      $display("t2 end");
      eventIn = 32'h24;
      acc(W, 7'h0d, 32'h20);
      eventIn = 32'h0;
      chk(interruptOut_r, 1'h1);
      chk(spiStatusBits_r, 8'h02);
      acc(W, 7'h0c, 32'h4);
      acc(R, 7'h0e, 32'h24);
      chk(interruptOut_r, 1'h0);
      chk(spiStatusBits_r, 8'h02);
      acc(R, 7'h0e, 32'h4);
      acc(R, 7'h10, 32'h0);
      $display("t3 end");
      stop_test;
   end
endmodule
